// File: design/uawb_autobaud_counter.v
// Purpose: 16-bit baud measurement counter with wrap detection
// Assumes: run and clear are single-clock controls from the top
// Notes:   counter wraps on purpose; the top keeps the sticky flag
`timescale 1ns/1ps
`include "uawb_consts.vh"
module uawb_autobaud_counter (
  input  wire                     clock,
  input  wire                     resetn,
  input  wire                     run,
  input  wire                     clear,
  output reg  [`UAWB_DIV_W-1:0]   count_r,
  output wire                     wrapPulse
);
  assign wrapPulse = run & (count_r == `UAWB_COUNT_MAX);

  always @(posedge clock) begin
    if (!resetn) begin
      count_r <= {`UAWB_DIV_W{1'b0}};
    end else if (clear) begin
      count_r <= {`UAWB_DIV_W{1'b0}};
    end else if (run) begin
      count_r <= count_r + `UAWB_COUNT_ONE;
    end
  end
endmodule // uawb_autobaud_counter

// File: design/uawb_consts.vh
// Purpose: shared constants of the auto-baud and wake-on-break receiver
// Assumes: included by bare name from every design file
// Notes:   definitions only
`ifndef UAWB_CONSTS_VH
`define UAWB_CONSTS_VH

`define UAWB_DIV_W          16
`define UAWB_DATA_W         8
`define UAWB_DIV_RESET      16'h0067
`define UAWB_COUNT_MAX      16'hFFFF
`define UAWB_COUNT_ONE      16'h0001
`define UAWB_EDGE_W         3
`define UAWB_EDGE_LAST      3'h5
`define UAWB_EDGE_FIRST     3'h1
`define UAWB_EDGE_ONE       3'h1
`define UAWB_BIT_W          3
`define UAWB_BIT_LAST       3'h7
`define UAWB_BIT_ONE        3'h1
`define UAWB_AB_SHIFT       3

`endif

// File: design/uawb_edge_detect.v
// Purpose: edge pulses and registered level of the receive line
// Assumes: line input already synchronous to clock
// Notes:   line idles high, so the history resets high
`timescale 1ns/1ps
`include "uawb_consts.vh"
module uawb_edge_detect (
  input  wire clock,
  input  wire resetn,
  input  wire lineIn,
  output wire lineLevel,
  output wire risePulse,
  output wire fallPulse
);
  reg linePrev_r;

  always @(posedge clock) begin
    if (!resetn) begin
      linePrev_r <= 1'b1;
    end else begin
      linePrev_r <= lineIn;
    end
  end

  assign lineLevel = linePrev_r;
  assign risePulse = lineIn & ~linePrev_r;
  assign fallPulse = ~lineIn & linePrev_r;
endmodule // uawb_edge_detect

// File: design/uawb_top.v
// Purpose: async serial receiver with auto-baud overflow and wake-on-break
// Assumes: all inputs synchronous to clock; control bits are plain ports
// Notes:   sleepMode models the stopped peripheral clock by freezing state
//
// Overview of operation
// - Set overflow flag when measurement counter wraps past 16 bits before fifth rise.
// - After overflow the measurement counter keeps running until the fifth rise.
// - Fifth rising edge sets receive flag and clears auto-baud enable.
// - Reading receive data clears the receive flag raised by auto-baud end.
// - Software may clear the overflow flag directly.
// - Overflow clear is ignored while auto-baud enable stays set.
// - In sleep the baud generator and character reception are frozen.
// - Wake-on-break can be armed only in asynchronous mode.
// - Wake-on-break enable suspends normal reception; receiver stays idle.
// - Falling receive edge is the wake-up event while wake-on-break is armed.
// - Wake raises receive flag at once; asynchronous output covers sleep.
// - Reading receive data clears the wake-up receive flag.
// - Rising edge ending the break clears wake enable; receiver waits idle.
// - Any low span counts as wake regardless of its length.
// - Receive-idle status is readable before arming wake-on-break.
`timescale 1ns/1ps
`include "uawb_consts.vh"
module uawb_top (
  input  wire                     clock,
  input  wire                     resetn,
  input  wire                     receiveLinePin,
  input  wire                     asyncMode,
  input  wire                     receiverEnable,
  input  wire                     sleepMode,
  input  wire                     autobaudSet,
  input  wire                     autobaudClear,
  input  wire                     overflowClear,
  input  wire                     wakeSet,
  input  wire                     wakeClear,
  input  wire                     divisorWrite,
  input  wire [`UAWB_DIV_W-1:0]   divisorIn,
  input  wire                     dataRead,
  input  wire                     errorClear,
  output wire [`UAWB_DATA_W-1:0]  receiveData,
  output wire [7:0]               baudDivisorHigh,
  output wire [7:0]               baudDivisorLow,
  output wire                     receiveInterruptFlag,
  output wire                     autobaudEnable,
  output wire                     autobaudOverflowFlag,
  output wire                     wakeOnBreakEnable,
  output wire                     receiveIdleFlag,
  output wire                     framingError,
  output wire                     overrunError,
  output wire                     wakeUpAsync
);
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_DATA  = 2'h2;
  localparam [1:0] ST_STOP  = 2'h3;

  reg  [1:0]               rxState_r;
  reg  [1:0]               rxState_nxt;
  reg  [`UAWB_DIV_W-1:0]   bitTimer_r;
  reg  [`UAWB_DIV_W-1:0]   bitTimer_nxt;
  reg  [`UAWB_BIT_W-1:0]   bitIndex_r;
  reg  [`UAWB_BIT_W-1:0]   bitIndex_nxt;
  reg  [`UAWB_DATA_W-1:0]  shift_r;
  reg  [`UAWB_DATA_W-1:0]  shift_nxt;
  reg  [`UAWB_DATA_W-1:0]  rxData_r;
  reg  [`UAWB_DIV_W-1:0]   divisor_r;
  reg                      rxFlag_r;
  reg                      abEnable_r;
  reg                      abOverflow_r;
  reg  [`UAWB_EDGE_W-1:0]  abEdges_r;
  reg                      wakeEnable_r;
  reg                      wakeLow_r;
  reg                      frameErr_r;
  reg                      overrunErr_r;

  wire                     lineLevel;
  wire                     lineRise;
  wire                     lineFall;
  wire [`UAWB_DIV_W-1:0]   abCount;
  wire                     abWrap;
  wire                     running;
  wire                     rxAllowed;
  wire                     bitDone;
  wire                     halfDone;
  wire                     charDone;
  wire                     charGood;
  wire                     abFifth;
  wire                     abRun;
  wire                     abClear;
  wire                     wakeEvent;
  wire                     wakeEnd;

  uawb_edge_detect uawb_edge_detect_i (
    .clock     (clock),
    .resetn    (resetn),
    .lineIn    (receiveLinePin),
    .lineLevel (lineLevel),
    .risePulse (lineRise),
    .fallPulse (lineFall)
  );

  uawb_autobaud_counter uawb_autobaud_counter_i (
    .clock     (clock),
    .resetn    (resetn),
    .run       (abRun),
    .clear     (abClear),
    .count_r   (abCount),
    .wrapPulse (abWrap)
  );

  // Peripheral clocks are off in sleep, so receiver and auto-baud state may not advance
  assign running   = ~sleepMode;
  // Wake-on-break and auto-baud both take the line away from the receiver
  assign rxAllowed = running & receiverEnable & ~wakeEnable_r & ~abEnable_r;

  assign bitDone  = (bitTimer_r == divisor_r);
  assign halfDone = (bitTimer_r == (divisor_r >> 1));
  assign charDone = rxAllowed & (rxState_r == ST_STOP) & bitDone;
  assign charGood = charDone & receiveLinePin;

  // Measurement spans first to fifth rising edge of the sync character
  assign abRun   = running & abEnable_r & (abEdges_r != {`UAWB_EDGE_W{1'b0}});
  assign abClear = running & autobaudSet & ~abEnable_r;
  assign abFifth = running & abEnable_r & lineRise
                   & (abEdges_r == (`UAWB_EDGE_LAST - `UAWB_EDGE_ONE));

  // Edge logic keeps watching in sleep: it stands for the unclocked detector
  assign wakeEvent = wakeEnable_r & ~wakeLow_r & lineFall;
  assign wakeEnd   = wakeEnable_r & wakeLow_r & lineRise;
  // Combinational path so the wake request exists with no clock running
  assign wakeUpAsync = wakeEnable_r & ~receiveLinePin;

  always @* begin
    rxState_nxt  = rxState_r;
    bitTimer_nxt = bitTimer_r + `UAWB_COUNT_ONE;
    bitIndex_nxt = bitIndex_r;
    shift_nxt    = shift_r;
    if (!rxAllowed) begin
      rxState_nxt  = ST_IDLE;
      bitTimer_nxt = {`UAWB_DIV_W{1'b0}};
      bitIndex_nxt = {`UAWB_BIT_W{1'b0}};
    end else begin
      case (rxState_r)
        ST_IDLE: begin
          bitTimer_nxt = {`UAWB_DIV_W{1'b0}};
          if (lineFall) begin
            rxState_nxt = ST_START;
          end
        end
        ST_START: begin
          // Mid-bit recheck rejects glitches shorter than half a bit
          if (halfDone) begin
            bitTimer_nxt = {`UAWB_DIV_W{1'b0}};
            rxState_nxt  = receiveLinePin ? ST_IDLE : ST_DATA;
            bitIndex_nxt = {`UAWB_BIT_W{1'b0}};
          end
        end
        ST_DATA: begin
          if (bitDone) begin
            bitTimer_nxt = {`UAWB_DIV_W{1'b0}};
            shift_nxt    = {receiveLinePin, shift_r[`UAWB_DATA_W-1:1]};
            bitIndex_nxt = bitIndex_r + `UAWB_BIT_ONE;
            if (bitIndex_r == `UAWB_BIT_LAST) begin
              rxState_nxt = ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (bitDone) begin
            bitTimer_nxt = {`UAWB_DIV_W{1'b0}};
            rxState_nxt  = ST_IDLE;
          end
        end
        default: begin
          rxState_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      rxState_r  <= ST_IDLE;
      bitTimer_r <= {`UAWB_DIV_W{1'b0}};
      bitIndex_r <= {`UAWB_BIT_W{1'b0}};
      shift_r    <= {`UAWB_DATA_W{1'b0}};
    end else if (running) begin
      rxState_r  <= rxState_nxt;
      bitTimer_r <= bitTimer_nxt;
      bitIndex_r <= bitIndex_nxt;
      shift_r    <= shift_nxt;
    end
  end

  // Received byte; a byte ending while the receive flag is set, as after a wake or auto-baud end, is discarded
  always @(posedge clock) begin
    if (!resetn) begin
      rxData_r <= {`UAWB_DATA_W{1'b0}};
    end else if (charDone & ~rxFlag_r) begin
      rxData_r <= shift_r;
    end
  end

  // Receive flag: any set in the same cycle as a read wins over the clear
  always @(posedge clock) begin
    if (!resetn) begin
      rxFlag_r <= 1'b0;
    end else if ((charDone & ~rxFlag_r) | abFifth | wakeEvent) begin
      rxFlag_r <= 1'b1;
    end else if (dataRead) begin
      rxFlag_r <= 1'b0;
    end
  end

  // Errors: a byte arriving over an unread one is dropped and flagged
  always @(posedge clock) begin
    if (!resetn) begin
      frameErr_r   <= 1'b0;
      overrunErr_r <= 1'b0;
    end else begin
      if (charDone & ~receiveLinePin) begin
        frameErr_r <= 1'b1;
      end else if (charGood | errorClear) begin
        frameErr_r <= 1'b0;
      end
      if (charDone & rxFlag_r) begin
        overrunErr_r <= 1'b1;
      end else if (errorClear) begin
        overrunErr_r <= 1'b0;
      end
    end
  end

  // Auto-baud enable and edge count
  always @(posedge clock) begin
    if (!resetn) begin
      abEnable_r <= 1'b0;
      abEdges_r  <= {`UAWB_EDGE_W{1'b0}};
    end else if (running) begin
      if (abFifth) begin
        abEnable_r <= 1'b0;
        abEdges_r  <= {`UAWB_EDGE_W{1'b0}};
      end else if (autobaudClear) begin
        abEnable_r <= 1'b0;
        abEdges_r  <= {`UAWB_EDGE_W{1'b0}};
      end else if (autobaudSet & ~abEnable_r) begin
        abEnable_r <= 1'b1;
        abEdges_r  <= {`UAWB_EDGE_W{1'b0}};
      end else if (abEnable_r & lineRise) begin
        abEdges_r <= abEdges_r + `UAWB_EDGE_ONE;
      end
    end
  end

  // Overflow flag: set wins over clear; clear needs the enable already low
  always @(posedge clock) begin
    if (!resetn) begin
      abOverflow_r <= 1'b0;
    end else if (abWrap & ~abFifth) begin
      abOverflow_r <= 1'b1;
    end else if (overflowClear & ~abEnable_r) begin
      abOverflow_r <= 1'b0;
    end
  end

  // Divisor: eight bit times lie between first and fifth rising edges
  always @(posedge clock) begin
    if (!resetn) begin
      divisor_r <= `UAWB_DIV_RESET;
    end else if (abFifth) begin
      divisor_r <= abCount >> `UAWB_AB_SHIFT;
    end else if (divisorWrite & ~abEnable_r) begin
      divisor_r <= divisorIn;
    end
  end

  // Wake-on-break enable; the low phase is tracked so a rise ends it
  always @(posedge clock) begin
    if (!resetn) begin
      wakeEnable_r <= 1'b0;
      wakeLow_r    <= 1'b0;
    end else if (wakeEnd) begin
      wakeEnable_r <= 1'b0;
      wakeLow_r    <= 1'b0;
    end else if (wakeEvent) begin
      wakeLow_r <= 1'b1;
    end else if (wakeClear) begin
      wakeEnable_r <= 1'b0;
      wakeLow_r    <= 1'b0;
    end else if (wakeSet & asyncMode & ~wakeEnable_r) begin
      wakeEnable_r <= 1'b1;
      wakeLow_r    <= 1'b0;
    end
  end

  assign receiveData          = rxData_r;
  assign baudDivisorHigh      = divisor_r[15:8];
  assign baudDivisorLow       = divisor_r[7:0];
  assign receiveInterruptFlag = rxFlag_r;
  assign autobaudEnable       = abEnable_r;
  assign autobaudOverflowFlag = abOverflow_r;
  assign wakeOnBreakEnable    = wakeEnable_r;
  // Idle only with no start bit being checked and no byte in assembly
  assign receiveIdleFlag      = (rxState_r == ST_IDLE);
  assign framingError         = frameErr_r;
  assign overrunError         = overrunErr_r;
endmodule // uawb_top

// File: verif/uawb_top_asserts.sv
// Purpose: port-level checks of auto-baud and wake-on-break behaviour
// Assumes: one clock domain, synchronous active-low reset
// Notes:   wake latencies allow one stage of line registering
`timescale 1ns/1ps
`include "uawb_consts.vh"
module uawb_top_asserts (
  input wire                    clock,
  input wire                    resetn,
  input wire                    receiveLinePin,
  input wire                    asyncMode,
  input wire                    sleepMode,
  input wire                    autobaudClear,
  input wire                    dataRead,
  input wire [`UAWB_DATA_W-1:0] receiveData,
  input wire                    receiveInterruptFlag,
  input wire                    autobaudEnable,
  input wire                    autobaudOverflowFlag,
  input wire                    wakeOnBreakEnable,
  input wire                    receiveIdleFlag,
  input wire                    wakeUpAsync
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_ovf_sticky: assert property (autobaudOverflowFlag && autobaudEnable |=>
    autobaudOverflowFlag) else $error("overflow flag lost while enabled");
  chk_ab_end: assert property ($fell(autobaudEnable) && $past(resetn) &&
    !$past(autobaudClear) |-> receiveInterruptFlag) else $error("no flag at auto-baud end");
  chk_rx_clear: assert property (dataRead && receiveIdleFlag && !sleepMode &&
    !autobaudEnable && !wakeOnBreakEnable |=> !receiveInterruptFlag)
    else $error("data read left flag set");
  chk_sleep_freeze: assert property (sleepMode && resetn |=>
    $stable(receiveData) && $stable(autobaudEnable)) else $error("state moved in sleep");
  chk_wake_async: assert property ($rose(wakeOnBreakEnable) |-> $past(asyncMode))
    else $error("wake armed outside async mode");
  chk_wake_idle: assert property (wakeOnBreakEnable && receiveIdleFlag |=>
    receiveIdleFlag) else $error("reception while wake armed");
  chk_wake_fall: assert property (wakeOnBreakEnable && $fell(receiveLinePin) |->
    ##[1:2] receiveInterruptFlag) else $error("wake fall raised no flag");
  chk_async_wake: assert property (wakeUpAsync ==
    (wakeOnBreakEnable && !receiveLinePin)) else $error("async wake mismatch");
  chk_wake_end: assert property (wakeOnBreakEnable && $rose(receiveLinePin) |->
    ##[1:2] !wakeOnBreakEnable) else $error("wake enable not cleared");
endmodule // uawb_top_asserts
bind uawb_top uawb_top_asserts uawb_top_asserts_i (.clock(clock), .resetn(resetn),
  .receiveLinePin(receiveLinePin), .asyncMode(asyncMode), .sleepMode(sleepMode),
  .autobaudClear(autobaudClear), .dataRead(dataRead), .receiveData(receiveData),
  .receiveInterruptFlag(receiveInterruptFlag), .autobaudEnable(autobaudEnable),
  .autobaudOverflowFlag(autobaudOverflowFlag), .wakeOnBreakEnable(wakeOnBreakEnable),
  .receiveIdleFlag(receiveIdleFlag), .wakeUpAsync(wakeUpAsync));

// File: verif/uawb_top_tb.sv
// Purpose: directed test of auto-baud, overflow, sleep and wake-on-break
// Assumes: inputs change at the falling clock edge
// Notes:   overflow case idles about 66000 cycles past the first rise
`timescale 1ns/1ps
module uawb_top_tb;
  localparam logic [5:0] AB_SET = 6'h20, AB_CLR = 6'h10, OV_CLR = 6'h08;
  localparam logic [5:0] WK_SET = 6'h04, WK_CLR = 6'h02, RD = 6'h01;
  reg         clock, resetn, asyncMode, receiverEnable, sleepMode, divisorWrite, errorClear;
  reg  [5:0]  ctl;
  reg  [15:0] divisorIn;
  wire        line, rxFlag, abEn, ovf, wkEn, idle, wakeUpAsync, fErr, oErr;
  wire [7:0]  receiveData, divHi, divLo;
  int         n_fail, checks_done, cycles, i;
  uawb_tx_model txm_i (.clock(clock), .line(line));
  uawb_top uawb_top_i (.clock(clock), .resetn(resetn), .receiveLinePin(line),
    .asyncMode(asyncMode), .receiverEnable(receiverEnable), .sleepMode(sleepMode),
    .autobaudSet(ctl[5]), .autobaudClear(ctl[4]), .overflowClear(ctl[3]),
    .wakeSet(ctl[2]), .wakeClear(ctl[1]), .divisorWrite(divisorWrite),
    .divisorIn(divisorIn), .dataRead(ctl[0]), .errorClear(errorClear),
    .receiveData(receiveData), .baudDivisorHigh(divHi), .baudDivisorLow(divLo),
    .receiveInterruptFlag(rxFlag), .autobaudEnable(abEn), .autobaudOverflowFlag(ovf),
    .wakeOnBreakEnable(wkEn), .receiveIdleFlag(idle), .framingError(fErr),
    .overrunError(oErr), .wakeUpAsync(wakeUpAsync));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [5:0] m);
    ctl = m;
    @(negedge clock);
    ctl = 6'h00;
    @(negedge clock);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Budget covers the long overflow idle with margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    {resetn, asyncMode, sleepMode, divisorWrite, errorClear, ctl} = 0;
    receiverEnable = 1'b1;
    divisorIn = 16'h000F;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    check({divHi, divLo}, 16'h0067);
    check({rxFlag, abEn, ovf, wkEn, idle, wakeUpAsync}, 16'h0002);
    divisorWrite = 1'b1;
    @(negedge clock);
    divisorWrite = 1'b0;
    fork
      txm_i.sendByte(8'hA5, 16);
      begin repeat (40) @(negedge clock); check(idle, 1'b0); end
    join
    repeat (4) @(negedge clock);
    check({rxFlag, receiveData}, 16'h01A5);
    pulse(RD);
    check(rxFlag, 1'b0);
    sleepMode = 1'b1;
    txm_i.sendByte(8'h3C, 16);
    check({rxFlag, receiveData}, 16'h00A5);
    sleepMode = 1'b0;
    pulse(AB_SET);
    check(abEn, 1'b1);
    for (i = 0; i < 5; i++) begin
      txm_i.holdLevel(1'b0, 32);
      txm_i.holdLevel(1'b1, 32);
    end
    check({rxFlag, abEn, ovf}, 16'h0004);
    // Sync bits of 32 clocks give a divisor of one less
    check({divHi, divLo}, 16'h001F);
    pulse(RD);
    check(rxFlag, 1'b0);
    pulse(AB_SET);
    txm_i.holdLevel(1'b0, 8);
    txm_i.holdLevel(1'b1, 66000);
    check(ovf, 1'b1);
    pulse(OV_CLR);
    check(ovf, 1'b1);
    for (i = 0; i < 4; i++) begin
      txm_i.holdLevel(1'b0, 8);
      txm_i.holdLevel(1'b1, 8);
    end
    check({rxFlag, abEn, ovf}, 16'h0005);
    pulse(OV_CLR);
    check(ovf, 1'b0);
    pulse(RD);
    pulse(AB_SET);
    pulse(AB_CLR);
    check(abEn, 1'b0);
    pulse(WK_SET);
    check(wkEn, 1'b0);
    asyncMode = 1'b1;
    pulse(WK_SET);
    check(wkEn, 1'b1);
    sleepMode = 1'b1;
    fork
      txm_i.sendBreak(16);
      begin
        #1 check(wakeUpAsync, 1'b1);
        repeat (3) @(negedge clock);
        check({rxFlag, idle}, 16'h0003);
        repeat (60) @(negedge clock);
        check(idle, 1'b1);
      end
    join
    sleepMode = 1'b0;
    check({wkEn, rxFlag}, 16'h0001);
    pulse(RD);
    check(rxFlag, 1'b0);
    pulse(WK_SET);
    fork
      txm_i.sendByte(8'hF0, 16);
      begin
        repeat (3) @(negedge clock);
        check(rxFlag, 1'b1);
        // Awake here, so only the wake arming keeps the receiver idle
        repeat (40) @(negedge clock);
        check(idle, 1'b1);
      end
    join
    check(wkEn, 1'b0);
    pulse(WK_SET);
    pulse(WK_CLR);
    check(wkEn, 1'b0);
    divisorWrite = 1'b1;
    @(negedge clock);
    divisorWrite = 1'b0;
    // Wake flag still unread, so this byte is dropped as an overrun
    txm_i.sendByte(8'h55, 16);
    repeat (4) @(negedge clock);
    check({oErr, fErr, rxFlag, receiveData}, 16'h05A5);
    errorClear = 1'b1;
    @(negedge clock);
    errorClear = 1'b0;
    check({oErr, fErr}, 16'h0000);
    pulse(RD);
    // All-zero frame with a low stop bit
    txm_i.holdLevel(1'b0, 160);
    txm_i.holdLevel(1'b1, 32);
    check({oErr, fErr, rxFlag, receiveData}, 16'h0300);
    test_done();
  end
endmodule // uawb_top_tb

// File: verif/uawb_tx_model.sv
// Purpose: remote async transmitter driving the receive line
// Assumes: line has a pull-up, so idle level is high
// Notes:   called at the falling clock edge; bit time given in clocks
`timescale 1ns/1ps
module uawb_tx_model (
  input  wire clock,
  output reg  line
);
  initial line = 1'b1;
  task automatic holdLevel(input logic lvl, input int clks);
    line = lvl;
    repeat (clks) @(negedge clock);
  endtask
  // Start, 8 data bits LSB first, stop
  task automatic sendByte(input logic [7:0] data, input int bitClks);
    int i;
    holdLevel(1'b0, bitClks);
    for (i = 0; i < 8; i++) holdLevel(data[i], bitClks);
    holdLevel(1'b1, bitClks);
  endtask
  // Longer than ten bits, then idle so the receiver can settle
  task automatic sendBreak(input int bitClks);
    holdLevel(1'b0, 13 * bitClks);
    holdLevel(1'b1, 4 * bitClks);
  endtask
endmodule // uawb_tx_model
